// [rtl/lcf_frame_config.sv]
`timescale 1ns/10ps

// Register map
// 0xe5 drive configuration, read and write
// 0xe5 fields: 7 clock source, 6 half bias, 5:4 duty, 3:0 segment mask
// 0xe6 frame rate, bits 7 and 3 read zero
// 0xe6 fields: 6:4 prescaler tap, 2:0 divide ratio
// 0xf0 control: bit 0 enable, bit 1 external clock
// 0xf1 interrupt status, read only
// 0xf2 interrupt clear, write only, reads zero
// 0xf3 interrupt enable
// Timing chain
// lcd tick -> prescaler tap (N) -> divider (D) -> prescaled tick
// prescaled tick -> frame phase (K periods) -> frame start
// The prescaler and divider advance only on the selected lcd tick, the frame phase on the prescaled tick
module lcf_frame_config
    import lcf_pkg::*;
#(
    parameter bit LARGE_VARIANT = 1'b1
) (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rstn,
    // Register port
    input  wire lcf_bus_req_t            busReq,
    output logic [7:0]                   rdata,
    // Asynchronous clock sources as ticks
    input  wire logic                    oscTick,
    input  wire logic                    extClkTick,
    // Frame timing
    output logic                         prescaledClkTick,
    output logic                         frameStart,
    output logic [2:0]                   framePhase,
    // Drive modes for the analog stage
    output lcf_bias_t                    biasMode,
    output lcf_duty_t                    dutyMode,
    // Pin ownership
    output logic [LCF_COM_PINS-1:0]      comActive,
    output logic [LCF_SEG_PINS-1:0]      segActive,
    // Level interrupt
    output logic                         irq
);

    // Software-visible state
    lcf_drive_config_t driveCfg;
    lcf_frame_rate_t   frameCfg;
    logic              lcdEnable;
    logic              extClkSel;
    logic [0:0]        irqStatus;
    logic [0:0]        irqEnable;

    // Frame-timing chain
    logic              lcdTick;
    logic [11:0]       psCount;
    logic [11:0]       psMask;
    logic              psTick;
    logic [2:0]        divCount;
    logic [2:0]        frameLast;
    logic [5:0]        segCount;
    logic [3:0]        maskView;
    logic              frameEvent;
    logic              next_psClk;

    // Register strobes decoded from the port
    logic              wrDrive;
    logic              wrFrame;
    logic              wrCtrl;
    logic              wrIrqClear;
    logic              wrIrqEnable;
    logic [7:0]        next_rdata;

    // Mask as software sees it, with the absent bit forced low
    always_comb begin
        maskView = driveCfg.segment_pin_mask;
        if (!LARGE_VARIANT) begin
            maskView[LCF_SEG_MASK_TOP_BIT] = 1'b0;
        end
    end

    // Write strobe decode, one strobe per writable register
    always_comb begin
        wrDrive     = 1'b0;
        wrFrame     = 1'b0;
        wrCtrl      = 1'b0;
        wrIrqClear  = 1'b0;
        wrIrqEnable = 1'b0;
        if (busReq.wr) begin
            if (busReq.addr == LCF_DRIVE_CONFIG_ADDR) begin
                wrDrive = 1'b1;
            end else if (busReq.addr == LCF_FRAME_RATE_ADDR) begin
                wrFrame = 1'b1;
            end else if (busReq.addr == LCF_CTRL_ADDR) begin
                wrCtrl = 1'b1;
            end else if (busReq.addr == LCF_IRQ_CLEAR_ADDR) begin
                wrIrqClear = 1'b1;
            end else if (busReq.addr == LCF_IRQ_ENABLE_ADDR) begin
                wrIrqEnable = 1'b1;
            end
        end
    end

    // Drive configuration register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            driveCfg <= LCF_DRIVE_CONFIG_RST;
        end else if (wrDrive) begin
            driveCfg <= busReq.wdata;
        end
    end

    // Frame rate register; reserved bits never store a one
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            frameCfg <= LCF_FRAME_RATE_RST;
        end else if (wrFrame) begin
            frameCfg           <= busReq.wdata;
            frameCfg.reserved7 <= 1'b0;
            frameCfg.reserved3 <= 1'b0;
        end
    end

    // Control register: enable and external clock choice
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lcdEnable <= LCF_CTRL_RST[LCF_CTRL_ENABLE_BIT];
            extClkSel <= LCF_CTRL_RST[LCF_CTRL_EXTCLK_BIT];
        end else if (wrCtrl) begin
            lcdEnable <= busReq.wdata[LCF_CTRL_ENABLE_BIT];
            extClkSel <= busReq.wdata[LCF_CTRL_EXTCLK_BIT];
        end
    end

    // Interrupt enable register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irqEnable <= 1'b0;
        end else if (wrIrqEnable) begin
            irqEnable <= busReq.wdata[LCF_IRQ_FRAME_BIT];
        end
    end

    // Read multiplexer; unmapped and write-only addresses read zero
    always_comb begin
        next_rdata = 8'h00;
        if (busReq.rd) begin
            if (busReq.addr == LCF_DRIVE_CONFIG_ADDR) begin
                next_rdata = {driveCfg.clock_source_select, driveCfg.half_bias_select,
                              driveCfg.duty_select, maskView};
            end else if (busReq.addr == LCF_FRAME_RATE_ADDR) begin
                next_rdata = {1'b0, frameCfg.prescaler_tap_select,
                              1'b0, frameCfg.divide_ratio_select};
            end else if (busReq.addr == LCF_CTRL_ADDR) begin
                next_rdata = {6'h00, extClkSel, lcdEnable};
            end else if (busReq.addr == LCF_IRQ_STATUS_ADDR) begin
                next_rdata = {7'h00, irqStatus};
            end else if (busReq.addr == LCF_IRQ_ENABLE_ADDR) begin
                next_rdata = {7'h00, irqEnable};
            end
        end
    end

    // Read data register, valid in the cycle after the strobe only
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= 8'h00;
        end else begin
            rdata <= next_rdata;
        end
    end

    // LCD clock tick: system clock runs every cycle, async source ticks
    always_comb begin
        if (!driveCfg.clock_source_select) begin
            lcdTick = 1'b1;
        end else if (extClkSel) begin
            lcdTick = extClkTick;
        end else begin
            lcdTick = oscTick;
        end
    end

    // Prescaler tap mask, N minus one
    always_comb begin
        case (frameCfg.prescaler_tap_select)
            3'h0:    psMask = 12'h00f;
            3'h1:    psMask = 12'h03f;
            3'h2:    psMask = 12'h07f;
            3'h3:    psMask = 12'h0ff;
            3'h4:    psMask = 12'h1ff;
            3'h5:    psMask = 12'h3ff;
            3'h6:    psMask = 12'h7ff;
            default: psMask = 12'hfff;
        endcase
    end

    // Every tap mask holds the low four bits, so ticks stay at least 16 counts apart
    assign psTick = lcdTick && ((psCount & psMask) == psMask);

    // Prescaler counter, free running on the LCD clock
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            psCount <= 12'h000;
        end else if (!lcdEnable) begin
            psCount <= 12'h000;
        end else if (lcdTick) begin
            psCount <= psCount + 12'h001;
        end
    end

    // Divide by D, where D is the field plus one
    // The >= compare lets a smaller ratio apply without a wrap-around stall
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            divCount <= 3'h0;
        end else if (!lcdEnable) begin
            divCount <= 3'h0;
        end else if (psTick) begin
            if (divCount >= frameCfg.divide_ratio_select) begin
                divCount <= 3'h0;
            end else begin
                divCount <= divCount + 3'h1;
            end
        end
    end

    assign next_psClk = lcdEnable && psTick && (divCount >= frameCfg.divide_ratio_select);

    // Prescaled clock tick, once per N*D LCD clocks
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prescaledClkTick <= 1'b0;
        end else begin
            prescaledClkTick <= next_psClk;
        end
    end

    // Frame length depends on duty
    assign frameLast = (driveCfg.duty_select == LCF_DUTY_THIRD) ? LCF_K_THIRD
                                                                 : LCF_K_NORMAL;
    // A frame shortened mid-way wraps on the next prescaled tick instead of running past its end
    assign frameEvent = prescaledClkTick && (framePhase >= frameLast);

    // Phase within a frame, in prescaled periods
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            framePhase <= 3'h0;
        end else if (!lcdEnable) begin
            framePhase <= 3'h0;
        end else if (prescaledClkTick) begin
            if (framePhase >= frameLast) begin
                framePhase <= 3'h0;
            end else begin
                framePhase <= framePhase + 3'h1;
            end
        end
    end

    // Frame start pulse
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            frameStart <= 1'b0;
        end else begin
            frameStart <= frameEvent;
        end
    end

    // Sticky frame flag; a new frame wins over a clear in the same cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irqStatus <= 1'b0;
        end else if (frameEvent) begin
            irqStatus <= 1'b1;
        end else if (wrIrqClear && busReq.wdata[LCF_IRQ_FRAME_BIT]) begin
            irqStatus <= 1'b0;
        end
    end

    // Level interrupt, high while an enabled flag is set
    assign irq = irqStatus[0] && irqEnable[0];

    // Duty decode, copied straight from the register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dutyMode <= LCF_DUTY_STATIC;
        end else begin
            dutyMode <= driveCfg.duty_select;
        end
    end

    // Bias decode; static duty overrides the bias bit
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            biasMode <= LCF_BIAS_STATIC;
        end else if (driveCfg.duty_select == LCF_DUTY_STATIC) begin
            biasMode <= LCF_BIAS_STATIC;
        end else if (driveCfg.half_bias_select) begin
            biasMode <= LCF_BIAS_HALF;
        end else begin
            biasMode <= LCF_BIAS_THIRD;
        end
    end

    // Segment pin count from the mask
    always_comb begin
        case (maskView)
            4'h0:    segCount = 6'd13;
            4'h1:    segCount = 6'd15;
            4'h2:    segCount = 6'd17;
            4'h3:    segCount = 6'd19;
            4'h4:    segCount = 6'd21;
            4'h5:    segCount = 6'd23;
            4'h6:    segCount = 6'd24;
            4'h7:    segCount = 6'd25;
            4'h8:    segCount = 6'd27;
            4'h9:    segCount = 6'd29;
            4'ha:    segCount = 6'd31;
            4'hb:    segCount = 6'd33;
            4'hc:    segCount = 6'd35;
            4'hd:    segCount = 6'd37;
            4'he:    segCount = 6'd39;
            default: segCount = 6'd40;
        endcase
    end

    // Pin ownership: high means LCD drives it, low means port function
    genvar gi;
    generate
        for (gi = 0; gi < LCF_SEG_PINS; gi++) begin : g_seg
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    segActive[gi] <= 1'b0;
                end else begin
                    segActive[gi] <= lcdEnable && (6'(gi) < segCount);
                end
            end
        end
    endgenerate

    // Common ownership follows the duty choice
    generate
        for (gi = 0; gi < LCF_COM_PINS; gi++) begin : g_com
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    comActive[gi] <= 1'b0;
                end else begin
                    comActive[gi] <= lcdEnable && (2'(gi) <= driveCfg.duty_select);
                end
            end
        end
    endgenerate

endmodule // lcf_frame_config

// [rtl/lcf_pkg.sv]
package lcf_pkg;

    // Register offsets as printed; the added control registers follow them
    localparam logic [7:0] LCF_DRIVE_CONFIG_ADDR = 8'he5;
    localparam logic [7:0] LCF_FRAME_RATE_ADDR   = 8'he6;
    localparam logic [7:0] LCF_CTRL_ADDR         = 8'hf0;
    localparam logic [7:0] LCF_IRQ_STATUS_ADDR   = 8'hf1;
    localparam logic [7:0] LCF_IRQ_CLEAR_ADDR    = 8'hf2;
    localparam logic [7:0] LCF_IRQ_ENABLE_ADDR   = 8'hf3;

    // Reset values
    localparam logic [7:0] LCF_DRIVE_CONFIG_RST = 8'h00;
    localparam logic [7:0] LCF_FRAME_RATE_RST   = 8'h00;
    localparam logic [1:0] LCF_CTRL_RST         = 2'h0;

    // Field positions of the control register
    localparam int LCF_CTRL_ENABLE_BIT  = 0;
    localparam int LCF_CTRL_EXTCLK_BIT  = 1;
    // Field position of the frame start flag in the interrupt registers
    localparam int LCF_IRQ_FRAME_BIT    = 0;
    // Top bit of the segment pin mask, absent on the small variant
    localparam int LCF_SEG_MASK_TOP_BIT = 3;

    // Widths of the pin groups
    localparam int LCF_COM_PINS = 4;
    localparam int LCF_SEG_PINS = 40;

    // Frame length in prescaled clock periods
    localparam logic [2:0] LCF_K_NORMAL = 3'h7;  // Eight periods, minus one
    localparam logic [2:0] LCF_K_THIRD  = 3'h5;  // Six periods, minus one

    // Duty selections
    typedef enum logic [1:0] {
        LCF_DUTY_STATIC  = 2'b00,
        LCF_DUTY_HALF    = 2'b01,
        LCF_DUTY_THIRD   = 2'b10,
        LCF_DUTY_QUARTER = 2'b11
    } lcf_duty_t;

    // Bias modes driven to the analog stage
    typedef enum logic [1:0] {
        LCF_BIAS_STATIC = 2'b00,
        LCF_BIAS_THIRD  = 2'b01,
        LCF_BIAS_HALF   = 2'b10
    } lcf_bias_t;

    // Drive configuration register layout
    typedef struct packed {
        logic      clock_source_select;
        logic      half_bias_select;
        lcf_duty_t duty_select;
        logic [3:0] segment_pin_mask;
    } lcf_drive_config_t;

    // Frame rate register layout
    typedef struct packed {
        logic       reserved7;
        logic [2:0] prescaler_tap_select;
        logic       reserved3;
        logic [2:0] divide_ratio_select;
    } lcf_frame_rate_t;

    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } lcf_bus_req_t;

endpackage

// [sim/lcf_frame_config_chk.sv]
`timescale 1ns/10ps
module lcf_frame_config_chk
    import lcf_pkg::*;
(
    input wire logic                    clk,
    input wire logic                    rstn,
    input wire lcf_bus_req_t            busReq,
    input wire logic [7:0]              rdata,
    input wire logic                    prescaledClkTick,
    input wire logic                    frameStart,
    input wire logic [2:0]              framePhase,
    input wire lcf_bias_t               biasMode,
    input wire lcf_duty_t               dutyMode,
    input wire logic [LCF_COM_PINS-1:0] comActive,
    input wire logic [LCF_SEG_PINS-1:0] segActive
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    // Register answers, pin decode and frame timing
    a_frame_rsvd_zero: assert property ($past(busReq.rd) && $past(busReq.addr) == LCF_FRAME_RATE_ADDR
        |-> rdata[7] == 1'b0 && rdata[3] == 1'b0) else $error("frame rate reserved bit set");
    a_static_bias: assert property (dutyMode == LCF_DUTY_STATIC |-> biasMode == LCF_BIAS_STATIC)
        else $error("static duty without static bias");
    a_com_decode: assert property (comActive != 4'h0 |-> comActive == (4'h2 << dutyMode) - 4'h1)
        else $error("common pins do not match duty");
    a_seg_contig: assert property (segActive != 40'h0 |-> (segActive & (segActive + 40'h1)) == 40'h0
        && $countones(segActive) >= 13) else $error("segment pins not a run from zero");
    a_pins_enable: assert property (comActive[0] == segActive[0])
        else $error("commons and segments disagree on enable");
    a_tick_spacing: assert property (prescaledClkTick |=> !prescaledClkTick [*8])
        else $error("prescaled ticks too close");
    a_frame_pulse: assert property (frameStart |=> !frameStart [*5])
        else $error("frame starts too close");
    a_phase_step: assert property ($changed(framePhase)
        |-> framePhase == $past(framePhase) + 3'h1 || framePhase == 3'h0)
        else $error("frame phase skipped");

    // Main scenarios reached
    c_frame: cover property (frameStart);
    c_third_frame: cover property (dutyMode == LCF_DUTY_THIRD && frameStart);
    c_rate_read: cover property (busReq.rd && busReq.addr == LCF_FRAME_RATE_ADDR);
endmodule // lcf_frame_config_chk

bind lcf_frame_config lcf_frame_config_chk u_chk (.clk, .rstn, .busReq, .rdata, .prescaledClkTick,
    .frameStart, .framePhase, .biasMode, .dutyMode, .comActive, .segActive);

// [sim/lcf_glass_model.sv]
`timescale 1ns/10ps
// Glass side: timer oscillator and external clock that feed the async display clock
module lcf_glass_model #(
    parameter int OSC_DIV = 3,
    parameter int EXT_DIV = 5
) (
    input  wire logic clk,
    input  wire logic rstn,
    output logic      oscTick,
    output logic      extClkTick
);
    int oscCnt;
    int extCnt;

    // Free-running tick sources, one pulse per period
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            oscCnt     <= 0;
            extCnt     <= 0;
            oscTick    <= 1'b0;
            extClkTick <= 1'b0;
        end else begin
            oscCnt     <= (oscCnt == OSC_DIV - 1) ? 0 : oscCnt + 1;
            extCnt     <= (extCnt == EXT_DIV - 1) ? 0 : extCnt + 1;
            oscTick    <= (oscCnt == OSC_DIV - 1);
            extClkTick <= (extCnt == EXT_DIV - 1);
        end
    end
endmodule // lcf_glass_model

// [sim/segment_lcd_clock_and_frame_config_tb.sv]
`timescale 1ns/10ps
module segment_lcd_clock_and_frame_config_tb
    import lcf_pkg::*;
;
    logic clk, rstn, oscTick, extClkTick, prescaledClkTick, frameStart, irq;
    lcf_bus_req_t busReq;
    logic [7:0]  rdata;
    logic [2:0]  framePhase;
    lcf_bias_t   biasMode;
    lcf_duty_t   dutyMode;
    logic [3:0]  comActive;
    logic [39:0] segActive;
    int failures = 0, cmp_count = 0, cycles = 0;
    int segN [16] = '{13, 15, 17, 19, 21, 23, 24, 25, 27, 29, 31, 33, 35, 37, 39, 40};

    lcf_frame_config dut (.clk(clk), .rstn(rstn), .busReq(busReq), .rdata(rdata),
        .oscTick(oscTick), .extClkTick(extClkTick), .prescaledClkTick(prescaledClkTick),
        .frameStart(frameStart), .framePhase(framePhase), .biasMode(biasMode),
        .dutyMode(dutyMode), .comActive(comActive), .segActive(segActive), .irq(irq));
    lcf_glass_model glass (.clk(clk), .rstn(rstn), .oscTick(oscTick), .extClkTick(extClkTick));
    // Small variant, whose mask top bit is absent
    logic [7:0]  rdataSmall;
    logic [39:0] segSmall;
    lcf_frame_config #(.LARGE_VARIANT(1'b0)) dutSmall (.clk(clk), .rstn(rstn), .busReq(busReq),
        .rdata(rdataSmall), .oscTick(oscTick), .extClkTick(extClkTick), .prescaledClkTick(),
        .frameStart(), .framePhase(), .biasMode(), .dutyMode(), .comActive(),
        .segActive(segSmall), .irq());

    // Clock and hang guard
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            failures++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [39:0] exp, input logic [39:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Register port cycles
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        busReq <= {a, d, 1'b1, 1'b0};
        @(posedge clk);
        busReq.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
        @(posedge clk);
        busReq <= {a, 8'h00, 1'b0, 1'b1};
        @(posedge clk);
        busReq.rd <= 1'b0;
        @(negedge clk);
        chk(nm, {32'h0, exp}, {32'h0, rdata});
    endtask

    function automatic logic pulse(input bit frm);
        return frm ? frameStart : prescaledClkTick;
    endfunction
    task automatic waitp(input bit frm);
        int w;
        w = 0;
        do begin
            @(negedge clk);
            w++;
        end while (pulse(frm) !== 1'b1 && w < 40000);
    endtask
    // Program, skip the settling pulse, then measure one period in clocks
    task automatic run(input logic [7:0] cfg, frr, ctl, input bit frm, input int exp);
        int n;
        wr(LCF_DRIVE_CONFIG_ADDR, cfg);
        wr(LCF_FRAME_RATE_ADDR, frr);
        wr(LCF_CTRL_ADDR, ctl);
        waitp(frm);
        waitp(frm);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (pulse(frm) !== 1'b1 && n < 40000);
        chk("period", exp, n);
        if (frm) chk("phase", 40'h0, {37'h0, framePhase});
    endtask

    // Main sequence
    initial begin
        busReq = '0;
        rstn = 1'b0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        rd(LCF_DRIVE_CONFIG_ADDR, 8'h00, "cfg reset");
        rd(LCF_FRAME_RATE_ADDR, 8'h00, "rate reset");
        rd(8'h10, 8'h00, "unmapped");
        chk("com off", 40'h0, {36'h0, comActive});
        wr(LCF_FRAME_RATE_ADDR, 8'hff);
        rd(LCF_FRAME_RATE_ADDR, 8'h77, "rate rsvd");
        wr(LCF_DRIVE_CONFIG_ADDR, 8'ha5);
        rd(LCF_DRIVE_CONFIG_ADDR, 8'ha5, "cfg rw");
        $display("test registers done");
        wr(LCF_CTRL_ADDR, 8'h01);
        for (int i = 0; i < 8; i++) begin
            wr(LCF_DRIVE_CONFIG_ADDR, {1'b0, i[2], i[1:0], 4'h0});
            repeat (2) @(negedge clk);
            chk("duty", i[1:0], dutyMode);
            chk("bias", i[1:0] == 2'b00 ? LCF_BIAS_STATIC : i[2] ? LCF_BIAS_HALF : LCF_BIAS_THIRD,
                biasMode);
            chk("com", (4'h2 << i[1:0]) - 4'h1, comActive);
        end
        $display("test duty done");
        for (int i = 0; i < 16; i++) begin
            wr(LCF_DRIVE_CONFIG_ADDR, {4'h3, i[3:0]});
            repeat (2) @(negedge clk);
            chk("seg", (40'h1 << segN[i]) - 40'h1, segActive);
            chk("seg small", (40'h1 << segN[i % 8]) - 40'h1, segSmall);
        end
        rd(LCF_DRIVE_CONFIG_ADDR, 8'h3f, "cfg mask");
        chk("mask small", 40'h37, {32'h0, rdataSmall});
        $display("test segments done");
        run(8'h30, 8'h00, 8'h01, 1'b0, 16);
        run(8'h30, 8'h07, 8'h01, 1'b0, 128);
        run(8'h30, 8'h12, 8'h01, 1'b0, 192);
        run(8'h30, 8'h70, 8'h01, 1'b0, 4096);
        run(8'h00, 8'h00, 8'h01, 1'b1, 128);
        run(8'h20, 8'h00, 8'h01, 1'b1, 96);
        run(8'hb0, 8'h00, 8'h01, 1'b0, 48);
        run(8'hb0, 8'h00, 8'h03, 1'b0, 80);
        run(8'h30, 8'h00, 8'h01, 1'b1, 128);
        $display("test timing done");
        wr(LCF_IRQ_ENABLE_ADDR, 8'h01);
        waitp(1'b1);
        repeat (2) @(negedge clk);
        chk("irq set", 40'h1, irq);
        rd(LCF_IRQ_STATUS_ADDR, 8'h01, "status");
        wr(LCF_IRQ_ENABLE_ADDR, 8'h00);
        @(negedge clk);
        chk("irq masked", 40'h0, irq);
        wr(LCF_CTRL_ADDR, 8'h00);
        wr(LCF_IRQ_CLEAR_ADDR, 8'h01);
        wr(LCF_IRQ_ENABLE_ADDR, 8'h01);
        repeat (300) @(negedge clk);
        chk("irq clear", 40'h0, irq);
        chk("seg off", 40'h0, segActive);
        rd(LCF_IRQ_CLEAR_ADDR, 8'h00, "clear reg");
        $display("test interrupt done");
        give_verdict();
    end
endmodule // segment_lcd_clock_and_frame_config_tb
